// ===== rsq_pkg.sv
// rsq_pkg: constants, register map and carrier types of the start-up and fault sequencer
// assumes a 10 MHz core clock and a 32-bit classic wishbone register bus
package rsq_pkg;

  // clock and timing
  localparam int unsigned CLK_KHZ          = 10000;  // core clock rate in kHz
  localparam int unsigned START_DELAY_US   = 100;    // startup_delay_period, fixed
  localparam int unsigned START_DELAY_CYC  = (START_DELAY_US * CLK_KHZ) / 1000;
  localparam int unsigned SLEW_UV_PER_US   = 3250;   // ramp slew, 3.25 mV per us
  localparam int unsigned REF_LSB_UV       = 250;    // reference code step, 0.25 mV
  localparam int unsigned STEP_PERIOD_US   = 1;      // one ramp increment per us
  localparam int unsigned STEP_PERIOD_CYC  = (STEP_PERIOD_US * CLK_KHZ) / 1000;
  localparam int unsigned REF_W            = 16;     // reference code width
  localparam logic [REF_W-1:0] RAMP_STEP   =
    REF_W'((SLEW_UV_PER_US * STEP_PERIOD_US) / REF_LSB_UV);

  // start-up targets picked by the two sampled vid pins {data, clock}
  localparam logic [REF_W-1:0] BOOT_TARGET_0 = 16'h0FA0;  // 1.000 V
  localparam logic [REF_W-1:0] BOOT_TARGET_1 = 16'h0E10;  // 0.900 V
  localparam logic [REF_W-1:0] BOOT_TARGET_2 = 16'h0C80;  // 0.800 V
  localparam logic [REF_W-1:0] BOOT_TARGET_3 = 16'h0AF0;  // 0.700 V

  // phase counts
  localparam logic [2:0] PHASES_1 = 3'h1;
  localparam logic [2:0] PHASES_2 = 3'h2;
  localparam logic [2:0] PHASES_3 = 3'h3;
  localparam logic [2:0] PHASES_4 = 3'h4;

  // register map, byte addresses
  localparam logic [7:0] REG_CTRL   = 8'h00;  // rw, bit 0 software hold-off
  localparam logic [7:0] REG_STATUS = 8'h04;  // ro, sequencer state and flags
  localparam logic [7:0] REG_REF    = 8'h08;  // ro, {target, reference}
  localparam logic       CTRL_RESET = 1'h0;
  localparam int unsigned ST_POS_STATE = 0;   // status[3:0] state code
  localparam int unsigned ST_POS_PHASE = 4;   // status[6:4] phase count
  localparam int unsigned ST_POS_PG    = 8;   // status[8] power good
  localparam int unsigned ST_POS_UV    = 9;   // status[9] under-voltage
  localparam int unsigned ST_POS_LATCH = 10;  // status[10] latched off
  localparam int unsigned ST_POS_DRV   = 11;  // status[11] drives enabled

  typedef enum logic [3:0] {
    RSQ_OFF, RSQ_WAIT, RSQ_DELAY, RSQ_RAMP, RSQ_RUN, RSQ_OVP, RSQ_LATCHED
  } rsq_state_type;

  // asynchronous comparator and power-on flags
  typedef struct packed {
    logic logic_bias_ok;     // logic supply above its power-on level
    logic driver_bias_ok;    // driver supply above its power-on level
    logic gate_opt_bias_ok;  // gate optimisation supply above its power-on level
    logic enable_high;       // enable comparator output
    logic phase_two_sense;   // channel sense inputs tied high
    logic phase_three_sense;
    logic phase_four_sense;
    logic vid_serial_data;
    logic vid_serial_clock;
    logic feedback_above;    // feedback_node above the ramping reference
    logic ovp_trip;          // output_sense above overvoltage_trip level
    logic pg_ov_limit;       // output_sense above power-good ov limit
    logic ov_released;       // output_sense below the 400 mV release level
    logic uv_low;            // output below target minus 300 mV
    logic uv_recovered;      // output above target minus 250 mV
    logic overcurrent;       // overcurrent comparator on either output
  } rsq_flags_type;

  // drive commands to the power stages
  typedef struct packed {
    logic drive_en;   // normal switching allowed
    logic pwm_off;    // external pwm outputs forced to off command
    logic lower_on;   // lower switches forced on
  } rsq_drive_type;

endpackage

// ===== rsq_top.sv
// rsq_top: start-up sequencing, soft-start ramp, power good and fault latch-off
// assumes flags come from analog comparators on no clock, one core clock and a
// classic wishbone master; the only hard reset is the power-on flag set
`timescale 1ns/10ps
module rsq_top #(
  parameter int unsigned DELAY_CYC = rsq_pkg::START_DELAY_CYC  // fixed start delay
) (
  input  wire logic                         clk_i,
  input  wire logic                         rst_i,
  input  wire rsq_pkg::rsq_flags_type       flags_i,           // raw comparator flags
  input  wire logic                         wb_cyc_i,
  input  wire logic                         wb_stb_i,
  input  wire logic                         wb_we_i,
  input  wire logic [7:0]                   wb_adr_i,
  input  wire logic [3:0]                   wb_sel_i,
  input  wire logic [31:0]                  wb_dat_i,
  output logic [31:0]                       wb_dat_o,
  output logic                              wb_ack_o,
  output rsq_pkg::rsq_drive_type            drive_o,           // power stage commands
  output logic [rsq_pkg::REF_W-1:0]         ref_core_o,        // core reference code
  output logic [rsq_pkg::REF_W-1:0]         ref_nb_o,          // northbridge reference
  output logic [2:0]                        phase_count_o,     // active core phases
  output logic                              power_good_out_o,  // open-drain data, low
  output logic                              power_good_oe_o    // high while pulling low
);
  import rsq_pkg::*;

  rsq_flags_type   flags_meta;     // first stage, read only by the second
  rsq_flags_type   flags;          // synchronised flags
  rsq_state_type   state;
  rsq_state_type   next_state;
  logic [REF_W-1:0] target;        // sampled start-up target
  logic [REF_W-1:0] dac_ref;       // ramping reference
  logic [9:0]      delay_cnt;      // start delay counter
  logic [3:0]      step_cnt;       // ramp increment pacing
  logic [2:0]      phases;         // latched phase count
  logic            drv_on;         // prebias release seen
  logic            uv_flag;        // under-voltage indication
  logic            hold_off;       // software hold-off
  logic            bias_ok;        // all three bias flags
  logic            ov_event;       // both ov comparators
  logic            start_ok;       // every precondition met
  logic            delay_done;
  logic            ramp_done;
  logic            pg_next;

  // phase count from the three sense straps
  function automatic logic [2:0] phase_decode(input logic two, input logic three,
                                              input logic four);
    if (two && three && four) begin
      phase_decode = PHASES_1;
    end else if (three && four) begin
      phase_decode = PHASES_2;
    end else if (four) begin
      phase_decode = PHASES_3;
    end else begin
      phase_decode = PHASES_4;
    end
  endfunction

  // boot target from the vid pins sampled at enable
  function automatic logic [REF_W-1:0] boot_target(input logic [1:0] code);
    unique case (code)
      2'h0: boot_target = BOOT_TARGET_0;
      2'h1: boot_target = BOOT_TARGET_1;
      2'h2: boot_target = BOOT_TARGET_2;
      2'h3: boot_target = BOOT_TARGET_3;
    endcase
  endfunction

  // two-flop synchroniser for every analog flag
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags_meta <= '0;
      flags      <= '0;
    end else begin
      flags_meta <= flags_i;
      flags      <= flags_meta;
    end
  end

  assign bias_ok  = flags.logic_bias_ok && flags.driver_bias_ok && flags.gate_opt_bias_ok;
  assign ov_event = flags.ovp_trip && flags.pg_ov_limit;
  // other inputs count only once logic bias is up
  assign start_ok = flags.logic_bias_ok && bias_ok && flags.enable_high
                    && !hold_off;
  assign delay_done = (delay_cnt == 10'(DELAY_CYC - 1));
  assign ramp_done  = (dac_ref == target);

  // sequencing state machine
  always_comb begin
    next_state = state;
    unique case (state)
      RSQ_OFF: begin
        if (flags.logic_bias_ok) begin
          next_state = RSQ_WAIT;
        end
      end
      RSQ_WAIT: begin
        if (start_ok) begin
          next_state = RSQ_DELAY;
        end
      end
      RSQ_DELAY: begin
        if (delay_done) begin
          next_state = RSQ_RAMP;
        end
      end
      RSQ_RAMP: begin
        if (ramp_done) begin
          next_state = RSQ_RUN;
        end
      end
      RSQ_RUN: begin
        next_state = RSQ_RUN;
      end
      RSQ_OVP: begin
        if (flags.ov_released) begin
          next_state = RSQ_LATCHED;
        end
      end
      RSQ_LATCHED: begin
        next_state = RSQ_LATCHED;
      end
    endcase
    // faults and disable override the normal flow
    if (state inside {RSQ_DELAY, RSQ_RAMP, RSQ_RUN}) begin
      if (flags.overcurrent) begin
        next_state = RSQ_LATCHED;
      end else if (!flags.enable_high || hold_off) begin
        next_state = RSQ_WAIT;
      end
    end
    if (state inside {RSQ_DELAY, RSQ_RAMP, RSQ_RUN, RSQ_LATCHED} && ov_event) begin
      next_state = RSQ_OVP;
    end
    // a bias drop is the only way out of a latch
    if (!bias_ok && state != RSQ_OFF && state != RSQ_WAIT) begin
      next_state = RSQ_OFF;
    end
    if (!flags.logic_bias_ok) begin
      next_state = RSQ_OFF;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= RSQ_OFF;
    end else begin
      state <= next_state;
    end
  end

  // start-up target and phase count, caught once at soft-start entry
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      target <= '0;
      phases <= PHASES_4;
    end else if (state == RSQ_WAIT && next_state == RSQ_DELAY) begin
      target <= boot_target({flags.vid_serial_data, flags.vid_serial_clock});
      phases <= phase_decode(flags.phase_two_sense, flags.phase_three_sense,
                             flags.phase_four_sense);
    end
    // otherwise held until enable low, hold-off, a bias drop or reset re-runs the entry
  end

  // start delay counter
  always_ff @(posedge clk_i) begin
    if (rst_i || state != RSQ_DELAY) begin
      delay_cnt <= '0;
    end else begin
      delay_cnt <= delay_cnt + 10'h001;
    end
  end

  // reference ramp, one step per microsecond, never past the target
  always_ff @(posedge clk_i) begin
    if (rst_i || state == RSQ_OFF || state == RSQ_WAIT || state == RSQ_DELAY) begin
      dac_ref  <= '0;  // held at zero through the delay
      step_cnt <= '0;
    end else if (state == RSQ_RAMP && !ramp_done) begin
      if (step_cnt == 4'(STEP_PERIOD_CYC - 1)) begin
        step_cnt <= '0;
        dac_ref  <= (target - dac_ref > RAMP_STEP) ? dac_ref + RAMP_STEP
                                                   : target;
      end else begin
        step_cnt <= step_cnt + 4'h1;
      end
    end
  end

  // prebias release: drives wait until reference passes feedback
  // the synced flag still compares against the loaded target for a few
  // cycles after the reference drops to zero, so wait for the first step
  always_ff @(posedge clk_i) begin
    if (rst_i || state != RSQ_RAMP && state != RSQ_RUN) begin
      drv_on <= 1'b0;
    end else if (state == RSQ_RAMP && ramp_done) begin
      drv_on <= 1'b1;  // ramp over, switch on regardless
    end else if (state == RSQ_RAMP && dac_ref != '0 && !flags.feedback_above) begin
      drv_on <= 1'b1;
    end else if (state == RSQ_RUN) begin
      drv_on <= 1'b1;
    end
  end

  // under-voltage flag; a new trip wins over recovery
  always_ff @(posedge clk_i) begin
    if (rst_i || state != RSQ_RUN) begin
      uv_flag <= 1'b0;
    end else if (flags.uv_low) begin
      uv_flag <= 1'b1;
    end else if (flags.uv_recovered) begin
      uv_flag <= 1'b0;
    end
  end

  // power good only in run, at target, with no fault
  assign pg_next = (state == RSQ_RUN) && (next_state == RSQ_RUN) && ramp_done
                   && !uv_flag && !flags.uv_low && !ov_event;

  // registered outputs to the stages and the power-good pin
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      drive_o          <= '0;
      power_good_out_o <= 1'b0;
      power_good_oe_o  <= 1'b1;
      ref_core_o       <= '0;
      ref_nb_o         <= '0;
      phase_count_o    <= PHASES_4;
    end else begin
      // pre-power-on: all commands off, lower switch left to the passive path
      drive_o.drive_en <= drv_on && state inside {RSQ_RAMP, RSQ_RUN};
      drive_o.pwm_off  <= state inside {RSQ_OVP, RSQ_LATCHED};
      drive_o.lower_on <= (state == RSQ_OVP);
      power_good_out_o <= 1'b0;
      power_good_oe_o  <= !pg_next;
      ref_core_o       <= (state == RSQ_DELAY) ? target : dac_ref;
      ref_nb_o         <= (state == RSQ_DELAY) ? target : dac_ref;
      phase_count_o    <= phases;
    end
  end

  // software hold-off register, byte 0 lane only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hold_off <= CTRL_RESET;
    end else if (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0]
                 && wb_adr_i == REG_CTRL) begin
      hold_off <= wb_dat_i[0];
    end
  end

  // wishbone answer: ack one cycle after the strobe, unmapped reads zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      wb_dat_o <= '0;
      unique case (wb_adr_i)
        REG_CTRL: begin
          wb_dat_o[0] <= hold_off;
        end
        REG_STATUS: begin
          wb_dat_o[ST_POS_STATE +: 4] <= state;
          wb_dat_o[ST_POS_PHASE +: 3] <= phases;
          wb_dat_o[ST_POS_PG]         <= !power_good_oe_o;
          wb_dat_o[ST_POS_UV]         <= uv_flag;
          wb_dat_o[ST_POS_LATCH]      <= state inside {RSQ_OVP, RSQ_LATCHED};
          wb_dat_o[ST_POS_DRV]        <= drive_o.drive_en;
        end
        REG_REF: begin
          wb_dat_o <= {target, dac_ref};
        end
        default: begin
          wb_dat_o <= '0;
        end
      endcase
    end
  end

  // checks
  sequence ov_seen_s;
    state inside {RSQ_RAMP, RSQ_RUN} && ov_event && bias_ok;
  endsequence
  sequence ovp_drive_s;
    drive_o.lower_on && drive_o.pwm_off && !drive_o.drive_en;
  endsequence

  no_start_early_a: assert property (@(posedge clk_i) disable iff (rst_i)
    state == RSQ_WAIT && !start_ok |=> state != RSQ_DELAY)
    else $error("soft-start entered without preconditions");
  bias_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !flags.logic_bias_ok |=> state == RSQ_OFF)
    else $error("sequencer left off without logic bias");
  phase_pick_a: assert property (@(posedge clk_i) disable iff (rst_i)
    state == RSQ_WAIT && next_state == RSQ_DELAY && flags.phase_four_sense
    && !flags.phase_three_sense |=> phases == PHASES_3)
    else $error("wrong phase count for fourth sense only");
  delay_len_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(state == RSQ_DELAY) |-> (state == RSQ_DELAY && dac_ref == '0)[*8])
    else $error("reference moved during start delay");
  ramp_bound_a: assert property (@(posedge clk_i) disable iff (rst_i)
    state == RSQ_RAMP |=> dac_ref <= target && dac_ref - $past(dac_ref) <= RAMP_STEP)
    else $error("ramp overshoot or step too large");
  pg_low_start_a: assert property (@(posedge clk_i) disable iff (rst_i)
    state inside {RSQ_OFF, RSQ_WAIT, RSQ_DELAY, RSQ_RAMP} |=> power_good_oe_o)
    else $error("power good released before run");
  prebias_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    state == RSQ_RAMP && flags.feedback_above && !drv_on |=> !drive_o.drive_en)
    else $error("drives on while feedback above reference");
  ov_response_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ov_seen_s |-> ##2 ovp_drive_s ##0 power_good_oe_o)
    else $error("overvoltage response missing");
  ov_latch_a: assert property (@(posedge clk_i) disable iff (rst_i)
    state == RSQ_LATCHED && bias_ok |=> state inside {RSQ_LATCHED, RSQ_OVP})
    else $error("left latch-off without power-on reset");
  uv_pull_a: assert property (@(posedge clk_i) disable iff (rst_i)
    state == RSQ_RUN && flags.uv_low |=> power_good_oe_o)
    else $error("power good high during under-voltage");

endmodule

// ===== rsq_front.sv
// rsq_front: behavioural analog front end facing the sequencer
// assumes the bench sets bias, enable, sense, vid and fault levels directly
`timescale 1ns/10ps
module rsq_front (
  input  wire logic                   clk_i,
  input  wire rsq_pkg::rsq_flags_type env_i,   // bench-set comparator levels
  input  wire rsq_pkg::rsq_drive_type drive_i, // power stage commands
  input  wire logic [15:0]            ref_i,   // ramping reference
  input  wire logic [15:0]            pre_i,   // pre-charged feedback level
  output rsq_pkg::rsq_flags_type      flags_o  // raw flags into the sequencer
);
  import rsq_pkg::*;
  logic [15:0] out_v;  // sensed output level, 0.25 mV codes
  initial out_v = 16'h0000;
  // lower switches drain the output fast; switching tracks the reference
  always @(posedge clk_i) begin
    if (drive_i.lower_on) begin
      out_v <= (out_v > 16'h0100) ? out_v - 16'h0100 : 16'h0000;
    end else if (drive_i.drive_en) begin
      out_v <= ref_i;
    end
  end
  // model-owned comparators; everything else passes from the bench
  always_comb begin
    flags_o                = env_i;
    flags_o.feedback_above = pre_i > ref_i;     // pre-charged node vs reference
    flags_o.ov_released    = out_v < 16'h0640;  // 400 mV release level
  end
endmodule

// ===== tb_rsq_top.sv
// tb_rsq_top: self-checking bench for the start-up and fault sequencer
// assumes the analog side is the rsq_front model and a short start delay
`timescale 1ns/10ps
module tb_rsq_top;
  import rsq_pkg::*;
  localparam int unsigned DLY = 20;  // shortened start delay, keeps run short
  logic          clk_i, rst_i, wb_cyc, wb_stb, wb_we, wb_ack, pg_out, pg_oe;
  logic [7:0]    wb_adr;
  logic [3:0]    wb_sel;
  logic [31:0]   wb_dat, wb_q, rd;
  logic [15:0]   ref_core, ref_nb, pre;
  logic [2:0]    phases;
  rsq_drive_type drv;
  rsq_flags_type env, flags;
  int            errors, checks, k, v;

  rsq_top #(.DELAY_CYC(DLY)) i_rsq_top (.clk_i(clk_i), .rst_i(rst_i), .flags_i(flags),
    .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
    .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_q), .wb_ack_o(wb_ack),
    .drive_o(drv), .ref_core_o(ref_core), .ref_nb_o(ref_nb), .phase_count_o(phases),
    .power_good_out_o(pg_out), .power_good_oe_o(pg_oe));
  rsq_front i_rsq_front (.clk_i(clk_i), .env_i(env), .drive_i(drv), .ref_i(ref_core),
    .pre_i(pre), .flags_o(flags));

  // clock, 100 ns period
  initial clk_i = 1'b0;
  always #50 clk_i = ~clk_i;

  // single value comparison, counted
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // verdict and end of run
  task stop_test;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // one classic wishbone cycle, held until ack is sampled
  task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {wb_cyc, wb_stb, wb_we, wb_adr, wb_dat, wb_sel} <= {2'h3, we, a, d, 4'hF};
    do begin
      @(posedge clk_i);
    end while (wb_ack !== 1'b1);
    rd = wb_q;
    {wb_cyc, wb_stb, wb_we} <= 3'h0;
    @(posedge clk_i);
  endtask
  // model tables: boot target from vid pins, phase count from senses
  function automatic logic [15:0] tgt(int vv);
    logic [15:0] t[4] = '{BOOT_TARGET_0, BOOT_TARGET_1, BOOT_TARGET_2, BOOT_TARGET_3};
    return t[vv];
  endfunction
  function automatic int ph(int s);
    return (s == 7) ? 1 : (s == 3) ? 2 : (s == 1) ? 3 : 4;
  endfunction
  // full start: preconditions, delay, ramp, power good
  task run_up(input int s, input int vv, input logic [15:0] p);
    int a, b, n;
    logic [15:0] t, last;
    t = tgt(vv);
    @(posedge clk_i);
    {env.phase_two_sense, env.phase_three_sense, env.phase_four_sense} <= s[2:0];
    {env.vid_serial_data, env.vid_serial_clock} <= vv[1:0];
    {env.logic_bias_ok, env.driver_bias_ok, env.gate_opt_bias_ok} <= 3'h7;
    env.enable_high <= 1'b1;
    pre <= p;
    for (a = 0; a < 200 && ref_core !== t; a++) @(posedge clk_i);
    for (b = 0; b < DLY + 50 && ref_core === t; b++) @(posedge clk_i);
    chk(a + b >= DLY && a + b <= DLY + 8, 1);
    chk(phases, ph(s));
    n = 0;
    last = ref_core;
    for (k = 0; k < 8000 && ref_core !== t; k++) begin
      @(posedge clk_i);
      if (ref_core !== last) begin
        n++;
        if (ref_core !== t) chk(ref_core - last, RAMP_STEP);
        last = ref_core;
      end
      chk(ref_nb, ref_core);
      chk(pg_oe, 1);
      if (p > ref_core + 16'h0100) chk(drv.drive_en, 0);
    end
    chk(n, (t + RAMP_STEP - 1) / RAMP_STEP);
    for (k = 0; k < 20 && pg_oe !== 1'b0; k++) @(posedge clk_i);
    chk(pg_oe, 0);
    chk(drv.drive_en, 1);
    {env.vid_serial_data, env.vid_serial_clock} <= ~vv[1:0];
    repeat (10) @(posedge clk_i);
    chk(ref_core, t);
  endtask

  // watchdog, well beyond the expected run length
  initial begin
    #(100 * 60000);
    errors++;
    stop_test;
  end

  // main sequence
  initial begin
    void'($urandom(32'hFAC26C51));
    {rst_i, wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_dat} = {1'b1, 45'h0};
    env = '0;
    env.uv_recovered = 1'b1;
    pre = 16'h0000;
    errors = 0;
    checks = 0;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk(drv, 0);
    chk(pg_oe, 1);
    // register access, read-only and unmapped places
    wb(1, REG_CTRL, 32'h1);
    wb(0, REG_CTRL, 0);
    chk(rd, 1);
    wb(1, REG_STATUS, 32'hFFFFFFFF);
    wb(0, 8'h0C, 0);
    chk(rd, 0);
    // hold-off keeps the sequencer waiting
    {env.logic_bias_ok, env.driver_bias_ok, env.gate_opt_bias_ok, env.enable_high} <= 4'hF;
    repeat (10) @(posedge clk_i);
    wb(0, REG_STATUS, 0);
    chk(rd[3:0], 1);
    // logic bias, driver bias and enable each missing in turn; hold-off lifted only once logic bias is gone
    {env.logic_bias_ok, env.enable_high} <= 2'h1;
    repeat (10) @(posedge clk_i);
    wb(1, REG_CTRL, 0);
    wb(0, REG_STATUS, 0);
    chk(rd[3:0], 0);
    {env.logic_bias_ok, env.driver_bias_ok} <= 2'h2;
    repeat (10) @(posedge clk_i);
    wb(0, REG_STATUS, 0);
    chk(rd[3:0], 1);
    {env.driver_bias_ok, env.enable_high} <= 2'h2;
    repeat (10) @(posedge clk_i);
    wb(0, REG_STATUS, 0);
    chk(rd[3:0], 1);
    // every phase option, random boot target, with and without pre-charge
    for (int i = 0; i < 4; i++) begin
      v = $urandom % 4;
      run_up((i == 0) ? 0 : (1 << i) - 1, v, (i == 1) ? 16'h0800 : (i == 2) ? 16'h1000 : 0);
      env.enable_high <= 1'b0;
      for (k = 0; k < 10 && pg_oe !== 1'b1; k++) @(posedge clk_i);
      chk(pg_oe, 1);
      repeat (5) @(posedge clk_i);
    end
    // under-voltage only touches power good, with hysteresis
    run_up(0, 0, 0);
    {env.uv_low, env.uv_recovered} <= 2'h2;
    repeat (10) @(posedge clk_i);
    chk(pg_oe, 1);
    chk(drv, 3'h4);
    env.uv_low <= 1'b0;
    repeat (10) @(posedge clk_i);
    chk(pg_oe, 1);
    env.uv_recovered <= 1'b1;
    repeat (10) @(posedge clk_i);
    chk(pg_oe, 0);
    // trip level alone is no over-voltage
    env.ovp_trip <= 1'b1;
    repeat (10) @(posedge clk_i);
    chk(drv, 3'h4);
    env.pg_ov_limit <= 1'b1;
    for (k = 0; k < 10 && drv.lower_on !== 1'b1; k++) @(posedge clk_i);
    chk(drv, 3'h3);
    chk(pg_oe, 1);
    {env.ovp_trip, env.pg_ov_limit} <= 2'h0;
    for (k = 0; k < 60 && drv.lower_on !== 1'b0; k++) @(posedge clk_i);
    chk(drv, 3'h2);
    {env.ovp_trip, env.pg_ov_limit} <= 2'h3;
    for (k = 0; k < 10 && drv.lower_on !== 1'b1; k++) @(posedge clk_i);
    chk(drv.lower_on, 1);
    {env.ovp_trip, env.pg_ov_limit} <= 2'h0;
    env.enable_high <= 1'b0;
    repeat (10) @(posedge clk_i);
    env.enable_high <= 1'b1;
    repeat (50) @(posedge clk_i);
    chk(drv, 3'h2);
    chk(pg_oe, 1);
    env.driver_bias_ok <= 1'b0;
    repeat (10) @(posedge clk_i);
    chk(drv, 0);
    // overcurrent latches off after a fresh start
    run_up(0, 3, 0);
    env.overcurrent <= 1'b1;
    repeat (10) @(posedge clk_i);
    chk(pg_oe, 1);
    wb(0, REG_STATUS, 0);
    chk(rd[10], 1);
    stop_test;
  end
endmodule
